// file: bscce_core.sv
// Execute logic for bit-test-skip-if-set, subroutine call and register clear.
`timescale 1ns/1ps
`default_nettype none
`include "bscce_cfg.svh"
module bscce_core (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Instruction stream and operands, all from logic on mclk.
    input wire logic instCycleEn,
    input wire logic [13:0] instWord,
    input wire logic [7:0] regRdData,
    input wire logic [4:0] pc_upper_latch,
    // Program counter and execute results.
    output logic [12:0] pcQ,
    output logic nopExecQ,
    // Register file write port and zero flag set strobe.
    output logic regWrEnQ,
    output logic [6:0] regWrAddrQ,
    output logic [7:0] regWrDataQ,
    output logic zeroSetQ,
    // Current top of the return stack.
    output logic [12:0] top_of_stack
);
    bscce_stack_if stackBus ();

    bscce_pkg::bscce_state_e state_q;
    bscce_pkg::bscce_state_e state_d;
    bscce_pkg::bscce_pc_t pc_q;
    bscce_pkg::bscce_pc_t pc_d;
    logic nop_q;
    logic nop_d;
    logic wrEn_q;
    logic wrEn_d;
    logic [6:0] wrAddr_q;
    logic [6:0] wrAddr_d;
    logic [7:0] wrData_q;
    logic [7:0] wrData_d;
    logic zeroSet_q;
    logic zeroSet_d;
    logic push_q;
    logic push_d;
    bscce_pkg::bscce_pc_t pushData_q;
    bscce_pkg::bscce_pc_t pushData_d;
    logic testedBit;
    logic execNow;

    // Opcode decoders, each used by the execute logic and by its checks.
    function automatic logic test_bit_skip_if_set(input bscce_pkg::bscce_word_t w);
        return w[13:`BSCCE_SKIP_OP_LSB] == `BSCCE_OP_SKIP_SET;
    endfunction

    function automatic logic isCall(input bscce_pkg::bscce_word_t w);
        return w[13:`BSCCE_CALL_OP_LSB] == `BSCCE_OP_CALL;
    endfunction

    function automatic logic clear_file_register(input bscce_pkg::bscce_word_t w);
        return w[13:`BSCCE_CLEAR_OP_LSB] == `BSCCE_OP_CLEAR;
    endfunction

    // The register file presents the addressed register with the word, so the test is a mux.
    assign testedBit = regRdData[instWord[`BSCCE_BIT_MSB:`BSCCE_BIT_LSB]];
    assign execNow = instCycleEn && (state_q == bscce_pkg::ST_EXEC);

    // Next-state and result computation for one instruction cycle.
    always_comb
    begin
        state_d = state_q;
        pc_d = pc_q;
        nop_d = 1'b0;
        wrEn_d = 1'b0;
        wrAddr_d = wrAddr_q;
        wrData_d = `BSCCE_CLEAR_VALUE;
        zeroSet_d = 1'b0;
        push_d = 1'b0;
        pushData_d = pushData_q;
        if (instCycleEn)
        begin
            unique case (state_q)
                bscce_pkg::ST_EXEC:
                begin
                    pc_d = pc_q + `BSCCE_PC_ONE;
                    if (test_bit_skip_if_set(instWord))
                    begin
                        // Reads only; no write strobe and no flag strobe here.
                        if (testedBit)
                        begin
                            state_d = bscce_pkg::ST_FLUSH;
                            pc_d = pc_q + `BSCCE_PC_TWO;
                        end
                    end
                    else if (isCall(instWord))
                    begin
                        push_d = 1'b1;
                        pushData_d = pc_q + `BSCCE_PC_ONE;
                        pc_d = {pc_upper_latch[`BSCCE_LATCH_MSB:`BSCCE_LATCH_LSB],
                            instWord[`BSCCE_IMM_MSB:0]};
                        state_d = bscce_pkg::ST_FLUSH;
                    end
                    else if (clear_file_register(instWord))
                    begin
                        wrEn_d = 1'b1;
                        wrAddr_d = instWord[`BSCCE_REG_MSB:0];
                        zeroSet_d = 1'b1;
                    end
                end
                bscce_pkg::ST_FLUSH:
                begin
                    // The word presented now was prefetched behind a skip or call.
                    nop_d = 1'b1;
                    state_d = bscce_pkg::ST_EXEC;
                end
            endcase
        end
    end

    // Register stage; every output of the block except top_of_stack is one of these flops.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_q <= bscce_pkg::ST_EXEC;
            pc_q <= `BSCCE_PC_RESET;
            nop_q <= 1'b0;
            wrEn_q <= 1'b0;
            wrAddr_q <= 7'h00;
            wrData_q <= `BSCCE_CLEAR_VALUE;
            zeroSet_q <= 1'b0;
            push_q <= 1'b0;
            pushData_q <= `BSCCE_PC_RESET;
        end
        else
        begin
            state_q <= state_d;
            pc_q <= pc_d;
            nop_q <= nop_d;
            wrEn_q <= wrEn_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
            zeroSet_q <= zeroSet_d;
            push_q <= push_d;
            pushData_q <= pushData_d;
        end
    end

    // Push channel to the return stack.
    assign stackBus.push = push_q;
    assign stackBus.pushData = pushData_q;

    bscce_stack u_stack (
        .mclk(mclk),
        .reset(reset),
        .stackBus(stackBus)
    );

    // Output connections.
    assign pcQ = pc_q;
    assign nopExecQ = nop_q;
    assign regWrEnQ = wrEn_q;
    assign regWrAddrQ = wrAddr_q;
    assign regWrDataQ = wrData_q;
    assign zeroSetQ = zeroSet_q;
    assign top_of_stack = stackBus.top;

    // Checks, all in the mclk domain.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_skip_taken;
        execNow && test_bit_skip_if_set(instWord) && testedBit
            |=> state_q == bscce_pkg::ST_FLUSH && pc_q == $past(pc_q) + `BSCCE_PC_TWO;
    endproperty
    a_skip_taken: assert property (p_skip_taken) else $error("taken skip did not flush");

    property p_skip_not_taken;
        execNow && test_bit_skip_if_set(instWord) && !testedBit
            |=> state_q == bscce_pkg::ST_EXEC && pc_q == $past(pc_q) + `BSCCE_PC_ONE;
    endproperty
    a_skip_not_taken: assert property (p_skip_not_taken) else $error("untaken skip stalled");

    property p_flush_nop;
        instCycleEn && state_q == bscce_pkg::ST_FLUSH
            |=> nop_q && !wrEn_q && !zeroSet_q && !push_q && state_q == bscce_pkg::ST_EXEC;
    endproperty
    a_flush_nop: assert property (p_flush_nop) else $error("flushed word was executed");

    property p_skip_two_cycles;
        execNow && test_bit_skip_if_set(instWord) && testedBit ##1 instCycleEn
            |=> state_q == bscce_pkg::ST_EXEC;
    endproperty
    a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip length wrong");

    property p_call_push;
        execNow && isCall(instWord)
            |=> push_q && pushData_q == $past(pc_q) + `BSCCE_PC_ONE ##1 top_of_stack == $past(pushData_q);
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address not pushed");

    property p_call_target;
        execNow && isCall(instWord) |=> pc_q[10:0] == $past(instWord[10:0]);
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target low bits wrong");

    property p_call_upper;
        execNow && isCall(instWord) |=> pc_q[12:11] == $past(pc_upper_latch[4:3]);
    endproperty
    a_call_upper: assert property (p_call_upper) else $error("call upper bits wrong");

    property p_call_cycles;
        execNow && isCall(instWord)
            |=> state_q == bscce_pkg::ST_FLUSH && !zeroSet_q && !wrEn_q;
    endproperty
    a_call_cycles: assert property (p_call_cycles) else $error("call timing or flags wrong");

    property p_clear;
        execNow && clear_file_register(instWord)
            |=> wrEn_q && wrData_q == 8'h00 && zeroSet_q && wrAddr_q == $past(instWord[6:0]);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not write zero");

    property p_skip_quiet;
        execNow && test_bit_skip_if_set(instWord) |=> !wrEn_q && !zeroSet_q && !push_q;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("skip touched state");

    // Main scenarios.
    c_skip_taken: cover property (execNow && test_bit_skip_if_set(instWord) && testedBit);
    c_skip_not: cover property (execNow && test_bit_skip_if_set(instWord) && !testedBit);
    c_call: cover property (execNow && isCall(instWord) ##1 instCycleEn ##1 nop_q);
    c_clear: cover property (execNow && clear_file_register(instWord));
endmodule // bscce_core
`default_nettype wire

// file: bscce_cfg.svh
// Constants for the skip, call and clear execution block.
`ifndef BSCCE_CFG_SVH
`define BSCCE_CFG_SVH

// Opcode patterns, compared against the top bits of the instruction word.
`define BSCCE_OP_SKIP_SET 4'h7
`define BSCCE_OP_CALL 3'h4
`define BSCCE_OP_CLEAR 7'h03

// Field positions inside the 14-bit instruction word.
`define BSCCE_SKIP_OP_LSB 10
`define BSCCE_CALL_OP_LSB 11
`define BSCCE_CLEAR_OP_LSB 7
`define BSCCE_BIT_MSB 9
`define BSCCE_BIT_LSB 7
`define BSCCE_REG_MSB 6
`define BSCCE_IMM_MSB 10
`define BSCCE_LATCH_MSB 4
`define BSCCE_LATCH_LSB 3

// Reset values and sizes.
`define BSCCE_PC_RESET 13'h0000
`define BSCCE_PC_ONE 13'h0001
`define BSCCE_PC_TWO 13'h0002
`define BSCCE_CLEAR_VALUE 8'h00
`define BSCCE_STACK_DEPTH 8
`define BSCCE_STACK_PTR_W 3

`endif

// file: bscce_pkg.sv
// Types shared by the skip, call and clear execution block.
`default_nettype none
package bscce_pkg;
    typedef logic [12:0] bscce_pc_t;
    typedef logic [13:0] bscce_word_t;

    // Execute runs a fetched word; flush drops the prefetched word as a no-operation.
    typedef enum logic [1:0] {
        ST_EXEC = 2'h0,
        ST_FLUSH = 2'h1
    } bscce_state_e;
endpackage
`default_nettype wire

// file: bscce_stack_if.sv
// Push channel between the core and its return stack.
`timescale 1ns/1ps
`default_nettype none
interface bscce_stack_if;
    logic push;
    bscce_pkg::bscce_pc_t pushData;
    bscce_pkg::bscce_pc_t top;

    modport core (output push, output pushData, input top);
    modport stack (input push, input pushData, output top);
endinterface
`default_nettype wire

// file: bscce_stack.sv
// Hardware return stack: circular memory with a registered top entry.
`timescale 1ns/1ps
`default_nettype none
`include "bscce_cfg.svh"
module bscce_stack (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Push channel from the core.
    bscce_stack_if.stack stackBus
);
    bscce_pkg::bscce_pc_t mem [`BSCCE_STACK_DEPTH];
    logic [`BSCCE_STACK_PTR_W-1:0] ptr_q;
    logic [`BSCCE_STACK_PTR_W-1:0] ptr_d;
    bscce_pkg::bscce_pc_t top_q;
    bscce_pkg::bscce_pc_t top_d;

    // The pointer wraps, so a ninth push silently overwrites the oldest entry.
    always_comb
    begin
        ptr_d = ptr_q;
        top_d = top_q;
        if (stackBus.push)
        begin
            ptr_d = ptr_q + 3'h1;
            top_d = stackBus.pushData;
        end
    end

    // Registers only; the memory needs no reset because the top copy is the read port.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ptr_q <= 3'h0;
            top_q <= `BSCCE_PC_RESET;
        end
        else
        begin
            ptr_q <= ptr_d;
            top_q <= top_d;
        end
        if (stackBus.push)
        begin
            mem[ptr_q] <= stackBus.pushData;
        end
    end

    assign stackBus.top = top_q;

    // A push is visible as the new top one cycle later.
    property p_push_top;
        @(posedge mclk) disable iff (reset)
        stackBus.push |=> top_q == $past(stackBus.pushData);
    endproperty
    a_push_top: assert property (p_push_top) else $error("pushed address not on top");
endmodule // bscce_stack
`default_nettype wire

// file: bscce_mem_model.sv
// Behavioural program memory and register file facing the execution core.
`timescale 1ns/1ps
`default_nettype none
module bscce_mem_model (
    // Clock.
    input wire logic mclk,
    // Fetch and register read toward the core.
    input wire logic [12:0] pcQ,
    output logic [13:0] instWord,
    output logic [7:0] regRdData,
    // Register write from the core.
    input wire logic regWrEnQ,
    input wire logic [6:0] regWrAddrQ,
    input wire logic [7:0] regWrDataQ,
    // Preload port used by the bench.
    input wire logic wrProg,
    input wire logic wrReg,
    input wire logic [6:0] wrAddr,
    input wire logic [13:0] wrData
);
    logic [13:0] prog [32];
    logic [7:0] regs [128];

    // Memories start cleared so that no unknown word is ever fetched.
    initial
    begin
        foreach (prog[i]) prog[i] = 14'h0000;
        foreach (regs[i]) regs[i] = 8'h00;
    end

    // Only 32 words are kept, so high addresses alias onto low ones.
    assign instWord = prog[pcQ[4:0]];
    assign regRdData = regs[instWord[6:0]];

    // A core write lands after a preload on the same edge, so the core wins.
    always @(posedge mclk)
    begin
        if (wrProg)
        begin
            prog[wrAddr[4:0]] <= wrData;
        end
        if (wrReg)
        begin
            regs[wrAddr] <= wrData[7:0];
        end
        if (regWrEnQ)
        begin
            regs[regWrAddrQ] <= regWrDataQ;
        end
    end
endmodule // bscce_mem_model
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the skip, call and clear execution core.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk, reset, instCycleEn, wrProg, wrReg;
    logic [13:0] instWord, wrData;
    logic [7:0] regRdData, regWrDataQ;
    logic [4:0] latch;
    logic [12:0] pcQ, top_of_stack, expPc;
    logic nopExecQ, regWrEnQ, zeroSetQ;
    logic [6:0] regWrAddrQ, wrAddr;
    int error_cnt = 0;
    int tests_run = 0;

    bscce_core u_dut (.mclk(mclk), .reset(reset), .instCycleEn(instCycleEn),
        .instWord(instWord), .regRdData(regRdData), .pc_upper_latch(latch), .pcQ(pcQ),
        .nopExecQ(nopExecQ), .regWrEnQ(regWrEnQ), .regWrAddrQ(regWrAddrQ),
        .regWrDataQ(regWrDataQ), .zeroSetQ(zeroSetQ), .top_of_stack(top_of_stack));
    bscce_mem_model u_mem (.mclk(mclk), .pcQ(pcQ), .instWord(instWord),
        .regRdData(regRdData), .regWrEnQ(regWrEnQ), .regWrAddrQ(regWrAddrQ),
        .regWrDataQ(regWrDataQ), .wrProg(wrProg), .wrReg(wrReg), .wrAddr(wrAddr),
        .wrData(wrData));

    // Free-running 100 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // One comparison, counted; values are widened to the counter width.
    task chk(input logic [12:0] got, input logic [12:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    // Preloads one program word or one register through the model.
    task load(input logic isReg, input logic [6:0] a, input logic [13:0] d);
        @(posedge mclk);
        wrProg <= ~isReg;
        wrReg <= isReg;
        wrAddr <= a;
        wrData <= d;
        @(posedge mclk);
        wrProg <= 1'b0;
        wrReg <= 1'b0;
    endtask

    // One instruction cycle; hold keeps the enable up so the next cycle follows back to back.
    task step(input logic hold);
        if (!instCycleEn)
        begin
            @(posedge mclk);
            instCycleEn <= 1'b1;
        end
        @(posedge mclk);
        instCycleEn <= hold;
        #1;
    endtask

    // Taken skip at the top bit of the top register; a clear waits in the slot.
    task skip_taken;
        load(1'b1, 7'h7F, 14'h0080);
        load(1'b0, expPc[6:0], 14'h1FFF);
        load(1'b0, expPc[6:0] + 7'h02, 14'h0189);
        step(1'b1);
        chk(pcQ, expPc + 13'h0002, "skip target");
        chk(regWrEnQ, 13'h0000, "skip wrote");
        chk(zeroSetQ, 13'h0000, "skip flag");
        step(1'b0);
        chk(nopExecQ, 13'h0001, "no nop");
        chk(regWrEnQ, 13'h0000, "slot ran");
        chk(pcQ, expPc + 13'h0002, "pc moved in flush");
        expPc = expPc + 13'h0002;
    endtask

    // Skip on a clear bit falls through in one cycle.
    task skip_not_taken;
        load(1'b1, 7'h05, 14'h00FB);
        load(1'b0, expPc[6:0], 14'h1D05);
        step(1'b0);
        chk(pcQ, expPc + 13'h0001, "fall through");
        chk(nopExecQ, 13'h0000, "stray nop");
        chk(regWrEnQ, 13'h0000, "skip wrote");
        expPc = expPc + 13'h0001;
    endtask

    // Clear of a nonzero register.
    task clear_reg;
        load(1'b1, 7'h09, 14'h005A);
        load(1'b0, expPc[6:0], 14'h0189);
        step(1'b0);
        chk(regWrEnQ, 13'h0001, "no write");
        chk(regWrAddrQ, 13'h0009, "write addr");
        chk(regWrDataQ, 13'h0000, "write data");
        chk(zeroSetQ, 13'h0001, "zero flag");
        chk(pcQ, expPc + 13'h0001, "clear pc");
        expPc = expPc + 13'h0001;
    endtask

    // Call with a full immediate and latch bits 4:3 set to binary 10; a clear waits at the target.
    task call_sub;
        load(1'b0, 7'h0B, 14'h0189);
        load(1'b0, expPc[6:0], 14'h27AB);
        latch <= 5'h10;
        step(1'b1);
        chk(pcQ, 13'h17AB, "call target");
        chk(zeroSetQ, 13'h0000, "call flag");
        step(1'b0);
        chk(nopExecQ, 13'h0001, "call second cycle");
        chk(regWrEnQ, 13'h0000, "call slot ran");
        chk(zeroSetQ, 13'h0000, "call slot flag");
        chk(top_of_stack, expPc + 13'h0001, "return addr");
        chk(pcQ, 13'h17AB, "call pc moved");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need well under a thousand cycles.
    initial
    begin
        #20000;
        error_cnt++;
        final_report();
    end

    // Main sequence.
    initial
    begin
        reset = 1'b1;
        instCycleEn = 1'b0;
        wrProg = 1'b0;
        wrReg = 1'b0;
        wrAddr = 7'h00;
        wrData = 14'h0000;
        latch = 5'h00;
        expPc = 13'h0000;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        #1;
        chk(pcQ, 13'h0000, "reset pc");
        skip_taken();
        skip_not_taken();
        clear_reg();
        call_sub();
        final_report();
    end
endmodule // tb
`default_nettype wire
